// File: verilog/msv_consts.vh
// Purpose: constants for the ethernet mac sideband vector block
// Assumes: apb byte addresses, 32-bit data
// Notes:   definitions only
`ifndef MSV_CONSTS_VH
`define MSV_CONSTS_VH

// register byte addresses
`define MSV_ADDR_W          8
`define MSV_OFF_RXCFG       8'h00
`define MSV_OFF_STATUS      8'h04
`define MSV_OFF_TXSTAT      8'h08
`define MSV_OFF_TXFRAMES    8'h0c
`define MSV_OFF_TXBAD       8'h10
`define MSV_OFF_RXFRAMES    8'h14

// receive configuration fields
`define MSV_CFG_W           4
`define MSV_CFG_RST         4'h0
`define MSV_CFG_RXRST       0
`define MSV_CFG_RXEN        1
`define MSV_CFG_VLAN        2
`define MSV_CFG_FCS         3

// status fields
`define MSV_ST_W            3
`define MSV_ST_LOCAL        0
`define MSV_ST_REMOTE       1
`define MSV_ST_LINKINT      2

// transmit statistics fields
`define MSV_TX_OK           0
`define MSV_TX_BCAST        1
`define MSV_TX_MCAST        2
`define MSV_TX_UNDERRUN     3
`define MSV_TX_CTRL         4
`define MSV_TX_LEN_LO       5
`define MSV_TX_LEN_HI       19
`define MSV_TX_VLAN         20
`define MSV_TX_BV_LO        21
`define MSV_TX_BV_HI        24
`define MSV_TX_PAUSE        25
`define MSV_TX_PFC          26
`define MSV_TX_W_BASE       26
`define MSV_RX_W_BASE       30
`define MSV_RX_VLAN_BIT     22

// lengths and limits
`define MSV_LEN_W           15
`define MSV_LEN_MAX         15'h7fff
`define MSV_MAXLEN_VLAN     16'h05f2
`define MSV_MAXLEN_PLAIN    16'h05ee
`define MSV_BV_W            4
`define MSV_BV_MAX          4'h8
`define MSV_CNT_W           32

`endif

// File: verilog/msv_sideband.v
// Purpose: receive configuration, fault status and statistics vectors
// Assumes: one clock for rx, tx and apb; inputs from same-clock mac logic
// Notes:   apb answers with no wait states; unmapped addresses give pslverr
//          writes to read-only registers are dropped without an error
//          event counters stick at all ones rather than wrapping
//          tx byte counts above 8 are clamped, not flagged
//          bytes seen between frames are counted into the next frame
//          the rx vlan drop keys off bit 22 of the receive vector
//          the receive path reset also follows the system reset
//
// Function
// - config bit 3 set passes fcs to client, clear strips; check always
// - config bit 2 allows vlan frames, max 1522; clear excludes, max 1518
// - receiver runs only while config bit 1 is set
// - config bit 0 high holds the receive path in reset
// - status bit 2 is read-only link interruption flag
// - status bit 1 is read-only remote fault flag
// - status bit 0 is read-only local fault flag, receive clock based
// - transmit statistics is 26 bits, 27 with priority flow control
// - receive statistics is 30 bits, 31 with pfc; own valid strobe
// - tx statistics driven after each frame; fields valid only on strobe
// - bits 24:21 give bytes sent last cycle, 0 to 8, every cycle
// - bit 26 flags a self-generated priority pause frame
// - bit 25 flags a pause frame sent for the client's pause request
// - bit 20 flags a vlan tagged frame with tx vlan enabled
// - bits 19:5 give frame length incl. pad and fcs, saturating 32767
// - bit 4 flags mac control type 88-08
// - bit 3 flags frame cut short by client underrun
// - bit 2 flags group addressed destination
// - bit 1 flags broadcast destination
// - bit 0 flags frame sent without error
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "msv_consts.vh"

module msv_sideband #(
	parameter PFC_EN  = 0,
	parameter TX_W    = `MSV_TX_W_BASE + PFC_EN,
	parameter RX_W    = `MSV_RX_W_BASE + PFC_EN
) (
	// clock and reset
	input  wire                    i_mclk,
	input  wire                    i_sys_rst,
	// apb slave
	input  wire                    i_psel,
	input  wire                    i_penable,
	input  wire                    i_pwrite,
	input  wire [`MSV_ADDR_W-1:0]  i_paddr,
	input  wire [31:0]             i_pwdata,
	input  wire [3:0]              i_pstrb,
	output wire                    o_pready,
	output wire                    o_pslverr,
	output reg  [31:0]             o_prdata,
	// receive control towards the receiver
	output wire                    o_rx_fcs_pass,
	output wire                    o_rx_vlan_en,
	output wire [15:0]             o_rx_max_len,
	output wire                    o_rx_enable,
	output wire                    o_rx_path_rst,
	// reconciliation sublayer fault state
	input  wire                    i_rs_local_fault,
	input  wire                    i_rs_remote_fault,
	input  wire                    i_rs_link_int,
	output wire [`MSV_ST_W-1:0]    o_status_vector,
	// transmit frame events from the transmitter
	input  wire [`MSV_BV_W-1:0]    i_tx_bytes,
	input  wire                    i_tx_frame_end,
	input  wire                    i_tx_pause,
	input  wire                    i_tx_pfc,
	input  wire                    i_tx_vlan,
	input  wire                    i_tx_ctrl,
	input  wire                    i_tx_underrun,
	input  wire                    i_tx_mcast,
	input  wire                    i_tx_bcast,
	input  wire                    i_tx_error,
	// transmit statistics
	output wire [TX_W-1:0]         o_tx_stat_vector,
	output reg                     o_tx_stat_valid,
	// receive statistics from the receiver, and out to the client
	input  wire [RX_W-1:0]         i_rx_stat_vector,
	input  wire                    i_rx_stat_valid,
	output reg  [RX_W-1:0]         o_rx_stat_vector,
	output reg                     o_rx_stat_valid
);

	function [`MSV_LEN_W-1:0] len_add;
		input [`MSV_LEN_W-1:0] acc;
		input [`MSV_BV_W-1:0]  add;
		reg   [`MSV_LEN_W:0]   sum;
		begin
			sum = {1'b0, acc} + {{(`MSV_LEN_W-`MSV_BV_W+1){1'b0}}, add};
			if (sum[`MSV_LEN_W])
				len_add = `MSV_LEN_MAX;
			else
				len_add = sum[`MSV_LEN_W-1:0];
		end
	endfunction

	function [`MSV_CNT_W-1:0] cnt_inc;
		input [`MSV_CNT_W-1:0] c;
		begin
			if (&c)
				cnt_inc = c;
			else
				cnt_inc = c + 32'h0000_0001;
		end
	endfunction

	// apb phases
	wire setup_ph = i_psel & ~i_penable;
	wire access_ph = i_psel & i_penable;
	wire wr_acc = access_ph & i_pwrite;

	reg  addr_ok;
	always @* begin
		case (i_paddr)
			`MSV_OFF_RXCFG,
			`MSV_OFF_STATUS,
			`MSV_OFF_TXSTAT,
			`MSV_OFF_TXFRAMES,
			`MSV_OFF_TXBAD,
			`MSV_OFF_RXFRAMES: addr_ok = 1'b1;
			default:           addr_ok = 1'b0;
		endcase
	end

	// zero wait states keeps the bus side trivial to time
	assign o_pready  = access_ph;
	assign o_pslverr = access_ph & ~addr_ok;

	// receive configuration register
	reg  [`MSV_CFG_W-1:0] cfg_reg;
	reg  [`MSV_CFG_W-1:0] cfg_next;
	always @* begin
		cfg_next = cfg_reg;
		if (wr_acc && i_paddr == `MSV_OFF_RXCFG && i_pstrb[0])
			cfg_next = i_pwdata[`MSV_CFG_W-1:0];
	end

	always @(posedge i_mclk) begin
		if (i_sys_rst)
			cfg_reg <= `MSV_CFG_RST;
		else
			cfg_reg <= cfg_next;
	end

	// receive control outputs; fcs is checked regardless of pass/strip
	assign o_rx_fcs_pass = cfg_reg[`MSV_CFG_FCS];
	assign o_rx_vlan_en  = cfg_reg[`MSV_CFG_VLAN];
	assign o_rx_max_len  = cfg_reg[`MSV_CFG_VLAN] ?
		`MSV_MAXLEN_VLAN : `MSV_MAXLEN_PLAIN;
	assign o_rx_path_rst = i_sys_rst | cfg_reg[`MSV_CFG_RXRST];
	assign o_rx_enable   = cfg_reg[`MSV_CFG_RXEN] & ~o_rx_path_rst;

	// fault status, registered once so all bits move on one edge
	reg  [`MSV_ST_W-1:0] status_reg;
	reg  [`MSV_ST_W-1:0] status_next;
	always @* begin
		status_next = status_reg;
		status_next[`MSV_ST_LINKINT] = i_rs_link_int;
		status_next[`MSV_ST_REMOTE]  = i_rs_remote_fault;
		status_next[`MSV_ST_LOCAL]   = i_rs_local_fault;
	end

	always @(posedge i_mclk) begin
		if (i_sys_rst)
			status_reg <= 3'h0;
		else
			status_reg <= status_next;
	end
	assign o_status_vector = status_reg;

	// transmit statistics: every flop has its own next value so the
	// capture condition sits in one place
	reg  [`MSV_BV_W-1:0]  bv_reg;
	reg  [`MSV_BV_W-1:0]  bv_next;

	reg  [`MSV_LEN_W-1:0] acc_reg;
	reg  [`MSV_LEN_W-1:0] acc_next;

	reg  [`MSV_LEN_W-1:0] len_reg;
	reg  [`MSV_LEN_W-1:0] len_next;

	reg                   valid_next;

	// per-frame flags
	reg                   ok_reg;
	reg                   ok_next;

	reg                   bcast_reg;
	reg                   bcast_next;

	reg                   mcast_reg;
	reg                   mcast_next;

	reg                   urun_reg;
	reg                   urun_next;

	reg                   ctrl_reg;
	reg                   ctrl_next;

	reg                   vlan_reg;
	reg                   vlan_next;

	reg                   pause_reg;
	reg                   pause_next;

	reg                   pfc_reg;
	reg                   pfc_next;

	// saturating event counters
	reg  [`MSV_CNT_W-1:0] txf_reg;
	reg  [`MSV_CNT_W-1:0] txf_next;

	reg  [`MSV_CNT_W-1:0] txbad_reg;
	reg  [`MSV_CNT_W-1:0] txbad_next;

	reg  [`MSV_CNT_W-1:0] rxf_reg;
	reg  [`MSV_CNT_W-1:0] rxf_next;

	// counts above 8 are protocol errors upstream; clamp rather than wrap
	wire [`MSV_BV_W-1:0] bytes_now = (i_tx_bytes > `MSV_BV_MAX) ?
		`MSV_BV_MAX : i_tx_bytes;
	wire [`MSV_LEN_W-1:0] len_now = len_add(acc_reg, bytes_now);
	wire tx_ok_now = ~i_tx_error & ~i_tx_underrun;

	// byte count, accumulator and strobe run every cycle; the rest moves only on frame end
	always @* begin
		// defaults hold every field except the byte count, accumulator and strobe
		bv_next    = bytes_now;
		valid_next = i_tx_frame_end;
		acc_next   = len_now;
		len_next   = len_reg;
		ok_next    = ok_reg;
		bcast_next = bcast_reg;
		mcast_next = mcast_reg;
		urun_next  = urun_reg;
		ctrl_next  = ctrl_reg;
		vlan_next  = vlan_reg;
		pause_next = pause_reg;
		pfc_next   = pfc_reg;
		txf_next   = txf_reg;
		txbad_next = txbad_reg;

		if (i_tx_frame_end) begin
			// bytes arriving between frames fold into the next frame
			acc_next   = {`MSV_LEN_W{1'b0}};
			len_next   = len_now;
			ok_next    = tx_ok_now;
			bcast_next = i_tx_bcast;
			mcast_next = i_tx_mcast;
			urun_next  = i_tx_underrun;
			ctrl_next  = i_tx_ctrl;
			vlan_next  = i_tx_vlan;
			pause_next = i_tx_pause;
			pfc_next   = i_tx_pfc & (PFC_EN != 0);
			txf_next   = cnt_inc(txf_reg);
			if (!tx_ok_now)
				txbad_next = cnt_inc(txbad_reg);
		end
	end

	// length path and strobe
	always @(posedge i_mclk) begin
		if (i_sys_rst) begin
			bv_reg          <= 4'h0;
			acc_reg         <= 15'h0000;
			len_reg         <= 15'h0000;
			o_tx_stat_valid <= 1'b0;
		end else begin
			bv_reg          <= bv_next;
			acc_reg         <= acc_next;
			len_reg         <= len_next;
			o_tx_stat_valid <= valid_next;
		end
	end

	// flags only change on the strobe edge, so they hold between frames
	always @(posedge i_mclk) begin
		if (i_sys_rst) begin
			ok_reg    <= 1'b0;
			bcast_reg <= 1'b0;
			mcast_reg <= 1'b0;
			urun_reg  <= 1'b0;
			ctrl_reg  <= 1'b0;
			vlan_reg  <= 1'b0;
			pause_reg <= 1'b0;
			pfc_reg   <= 1'b0;
		end else begin
			ok_reg    <= ok_next;
			bcast_reg <= bcast_next;
			mcast_reg <= mcast_next;
			urun_reg  <= urun_next;
			ctrl_reg  <= ctrl_next;
			vlan_reg  <= vlan_next;
			pause_reg <= pause_next;
			pfc_reg   <= pfc_next;
		end
	end

	// frame counters
	always @(posedge i_mclk) begin
		if (i_sys_rst) begin
			txf_reg   <= 32'h0000_0000;
			txbad_reg <= 32'h0000_0000;
		end else begin
			txf_reg   <= txf_next;
			txbad_reg <= txbad_next;
		end
	end

	// assemble vector; pfc bit only exists when built in
	wire [26:0] tx_full = {pfc_reg, pause_reg, bv_reg, vlan_reg, len_reg,
		ctrl_reg, urun_reg, mcast_reg, bcast_reg, ok_reg};
	assign o_tx_stat_vector = tx_full[TX_W-1:0];

	// receive statistics pass-through, gated by receiver state; a tagged
	// frame is dropped unless vlan reception is on
	reg  [RX_W-1:0] rxv_next;
	reg             rxval_next;
	wire rx_vlan_drop = i_rx_stat_vector[`MSV_RX_VLAN_BIT] &
		~cfg_reg[`MSV_CFG_VLAN];
	wire rx_take = i_rx_stat_valid & o_rx_enable & ~rx_vlan_drop;

	always @* begin
		rxv_next   = i_rx_stat_vector;
		rxval_next = rx_take;
		rxf_next   = rxf_reg;
		if (rx_take)
			rxf_next = cnt_inc(rxf_reg);
	end

	always @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_rx_stat_vector <= {RX_W{1'b0}};
			o_rx_stat_valid  <= 1'b0;
			rxf_reg          <= 32'h0000_0000;
		end else begin
			o_rx_stat_vector <= rxv_next;
			o_rx_stat_valid  <= rxval_next;
			rxf_reg          <= rxf_next;
		end
	end

	// apb read data, captured in setup so it stands through access
	reg  [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h0000_0000;
		case (i_paddr)
			`MSV_OFF_RXCFG:    rd_mux[`MSV_CFG_W-1:0] = cfg_reg;
			`MSV_OFF_STATUS:   rd_mux[`MSV_ST_W-1:0] = status_reg;
			`MSV_OFF_TXSTAT:   rd_mux[26:0] = tx_full;
			`MSV_OFF_TXFRAMES: rd_mux = txf_reg;
			`MSV_OFF_TXBAD:    rd_mux = txbad_reg;
			`MSV_OFF_RXFRAMES: rd_mux = rxf_reg;
			default:           rd_mux = 32'h0000_0000;
		endcase
	end

	// hold the last read word between transfers
	reg  [31:0] prdata_next;
	always @* begin
		prdata_next = o_prdata;
		if (setup_ph && !i_pwrite)
			prdata_next = rd_mux;
	end

	always @(posedge i_mclk) begin
		if (i_sys_rst)
			o_prdata <= 32'h0000_0000;
		else
			o_prdata <= prdata_next;
	end

endmodule

// File: dv/msv_sideband_assertions.sv
// Purpose: checker for the sideband vector block ports
// Assumes: one clock, synchronous active high reset
// Notes:   bound to every msv_sideband instance
`timescale 1ns/1ps
`include "msv_consts.vh"
module msv_sideband_assertions #(
	parameter TX_W = 27
) (
	input wire                   i_mclk, i_sys_rst,
	input wire                   i_psel, i_penable, i_pwrite,
	input wire [`MSV_ADDR_W-1:0] i_paddr,
	input wire [31:0]            i_pwdata,
	input wire [3:0]             i_pstrb,
	input wire                   o_rx_fcs_pass, o_rx_vlan_en,
	input wire [15:0]            o_rx_max_len,
	input wire                   o_rx_enable, o_rx_path_rst,
	input wire                   i_rs_local_fault, i_rs_remote_fault,
	input wire                   i_rs_link_int,
	input wire [`MSV_ST_W-1:0]   o_status_vector,
	input wire [`MSV_BV_W-1:0]   i_tx_bytes,
	input wire                   i_tx_frame_end, i_tx_pause, i_tx_vlan,
	input wire                   i_tx_ctrl, i_tx_underrun, i_tx_mcast,
	input wire                   i_tx_bcast, i_tx_error,
	input wire [TX_W-1:0]        o_tx_stat_vector,
	input wire                   o_tx_stat_valid
);
	wire       cfg_wr = i_psel & i_penable & i_pwrite & i_pstrb[0]
		& (i_paddr == `MSV_OFF_RXCFG);
	wire [2:0] st_in = {i_rs_link_int, i_rs_remote_fault, i_rs_local_fault};
	wire [4:0] lo_in = {i_tx_ctrl, i_tx_underrun, i_tx_mcast, i_tx_bcast,
		~i_tx_error & ~i_tx_underrun};
	wire [1:0] hi_in = {i_tx_pause, i_tx_vlan};
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	sequence s_stat_out;
		o_tx_stat_valid && o_tx_stat_vector[4:0] == $past(lo_in);
	endsequence
	a_fcs_pass_follow: assert property (cfg_wr |=>
		o_rx_fcs_pass == $past(i_pwdata[3])) else $error("fcs pass wrong");
	a_max_len_sel: assert property (o_rx_max_len == (o_rx_vlan_en ?
		`MSV_MAXLEN_VLAN : `MSV_MAXLEN_PLAIN)) else $error("max len wrong");
	a_rx_enable_cfg: assert property (cfg_wr |=> o_rx_enable ==
		($past(i_pwdata[1]) & !$past(i_pwdata[0]))) else $error("rx en");
	a_path_rst_cfg: assert property (cfg_wr |=>
		o_rx_path_rst == $past(i_pwdata[0])) else $error("path rst wrong");
	a_status_follow: assert property (!$past(i_sys_rst) |->
		o_status_vector == $past(st_in)) else $error("status wrong");
	a_bytes_prev: assert property (!$past(i_sys_rst) |->
		o_tx_stat_vector[24:21] == ($past(i_tx_bytes) > 4'h8 ? 4'h8 :
		$past(i_tx_bytes))) else $error("bytes field wrong");
	a_one_strobe: assert property (!$past(i_sys_rst) |->
		o_tx_stat_valid == $past(i_tx_frame_end)) else $error("strobe");
	a_low_flags: assert property (i_tx_frame_end |=>
		s_stat_out) else $error("low flags wrong");
	a_pause_vlan: assert property (i_tx_frame_end |=> {o_tx_stat_vector[25],
		o_tx_stat_vector[20]} == $past(hi_in)) else $error("flags");
	a_fields_hold: assert property (!$past(i_tx_frame_end) &&
		!$past(i_sys_rst) |-> $stable(o_tx_stat_vector[20:0]))
		else $error("fields moved between frames");
endmodule
bind msv_sideband msv_sideband_assertions #(.TX_W(TX_W)) u_chk (.i_mclk,
	.i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
	.i_pstrb, .o_rx_fcs_pass, .o_rx_vlan_en, .o_rx_max_len, .o_rx_enable,
	.o_rx_path_rst, .i_rs_local_fault, .i_rs_remote_fault, .i_rs_link_int,
	.o_status_vector, .i_tx_bytes, .i_tx_frame_end, .i_tx_pause, .i_tx_vlan,
	.i_tx_ctrl, .i_tx_underrun, .i_tx_mcast, .i_tx_bcast, .i_tx_error,
	.o_tx_stat_vector, .o_tx_stat_valid);

// File: dv/msv_client_model.sv
// Purpose: client that consumes transmit statistics
// Assumes: same clock as the block
// Notes:   keeps last vector and a frame count
`timescale 1ns/1ps
module msv_client_model #(
	parameter TX_W = 27
) (
	input  wire            i_mclk, i_sys_rst, i_stat_valid,
	input  wire [TX_W-1:0] i_stat,
	output reg  [TX_W-1:0] o_last,
	output reg  [15:0]     o_frames
);
	// fields are taken on the strobe only, never from idle cycles
	always @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_last <= {TX_W{1'b0}};
			o_frames <= 16'h0000;
		end else if (i_stat_valid) begin
			o_last <= i_stat;
			o_frames <= o_frames + 16'h0001;
		end
	end
endmodule

// File: dv/msv_sideband_tb.sv
// Purpose: self-checking bench for the sideband vector block
// Assumes: apb master tasks, client model on tx statistics
// Notes:   receive statistics inputs are driven one vector at a time by t_rx
`timescale 1ns/1ps
`include "msv_consts.vh"
module mac_sideband_vectors_tb;
	logic i_mclk, i_sys_rst, i_psel, i_penable, i_pwrite, er;
	logic [7:0] i_paddr, fl;
	logic [31:0] i_pwdata, rd;
	logic [3:0] i_pstrb, i_tx_bytes;
	logic i_rs_local_fault, i_rs_remote_fault, i_rs_link_int, i_tx_frame_end;
	wire i_tx_pfc, i_tx_pause, i_tx_vlan, i_tx_ctrl, i_tx_underrun;
	wire i_tx_mcast, i_tx_bcast, i_tx_error, o_pready, o_pslverr;
	wire o_rx_fcs_pass, o_rx_vlan_en, o_rx_enable, o_rx_path_rst;
	wire o_tx_stat_valid;
	wire [31:0] o_prdata;
	wire [15:0] o_rx_max_len, frames;
	wire [2:0] o_status_vector;
	wire [26:0] o_tx_stat_vector, last;
	logic [30:0] rxv;
	logic rxval;
	wire [30:0] orxv;
	wire orxval;
	int errors = 0, samples_checked = 0, nf = 0;
	assign {i_tx_pfc, i_tx_pause, i_tx_vlan, i_tx_ctrl, i_tx_underrun,
		i_tx_mcast, i_tx_bcast, i_tx_error} = fl;
	msv_sideband #(.PFC_EN(1)) DUT (.i_mclk, .i_sys_rst, .i_psel,
		.i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_pready,
		.o_pslverr, .o_prdata, .o_rx_fcs_pass, .o_rx_vlan_en, .o_rx_max_len,
		.o_rx_enable, .o_rx_path_rst, .i_rs_local_fault, .i_rs_remote_fault,
		.i_rs_link_int, .o_status_vector, .i_tx_bytes, .i_tx_frame_end,
		.i_tx_pause, .i_tx_pfc, .i_tx_vlan, .i_tx_ctrl, .i_tx_underrun,
		.i_tx_mcast, .i_tx_bcast, .i_tx_error, .o_tx_stat_vector,
		.o_tx_stat_valid, .i_rx_stat_vector(rxv), .i_rx_stat_valid(rxval),
		.o_rx_stat_vector(orxv), .o_rx_stat_valid(orxval));
	msv_client_model #(.TX_W(27)) u_client (.i_mclk, .i_sys_rst,
		.i_stat(o_tx_stat_vector), .i_stat_valid(o_tx_stat_valid),
		.o_last(last), .o_frames(frames));
	initial begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end
	task conclude;
		if (errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] v);
		samples_checked++;
		if (v !== e) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", n, e, v);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge i_mclk);
		{i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_pstrb} <=
			{2'b10, w, a, d, s};
		@(posedge i_mclk);
		i_penable <= 1'b1;
		@(posedge i_mclk);
		while (o_pready !== 1'b1) @(posedge i_mclk);
		rd = o_prdata;
		er = o_pslverr;
		{i_psel, i_penable} <= 2'b00;
	endtask
	task t_cfg;
		for (int i = 0; i < 16; i++) begin
			apb(1'b1, `MSV_OFF_RXCFG, i, 4'h1);
			@(negedge i_mclk);
			chk("fcs_pass", i[3], o_rx_fcs_pass);
			chk("max_len", i[2] ? `MSV_MAXLEN_VLAN : `MSV_MAXLEN_PLAIN,
				o_rx_max_len);
			chk("rx_enable", i[1] & ~i[0], o_rx_enable);
			chk("path_rst", i[0], o_rx_path_rst);
			apb(1'b0, `MSV_OFF_RXCFG, 32'h0, 4'h0);
			chk("cfg_read", i, rd);
		end
		apb(1'b1, `MSV_OFF_RXCFG, 32'h0, 4'h0);
		apb(1'b0, `MSV_OFF_RXCFG, 32'h0, 4'h0);
		chk("cfg_lane_off", 32'hf, rd);
		apb(1'b0, 8'h18, 32'h0, 4'h0);
		chk("unmapped_err", 1'b1, er);
	endtask
	task t_status;
		for (int i = 0; i < 8; i++) begin
			@(posedge i_mclk);
			{i_rs_link_int, i_rs_remote_fault, i_rs_local_fault} <= i[2:0];
			apb(1'b0, `MSV_OFF_STATUS, 32'h0, 4'h0);
			chk("status", i, o_status_vector);
			chk("status_read", i, rd);
		end
		apb(1'b1, `MSV_OFF_STATUS, 32'h0, 4'hf);
		apb(1'b0, `MSV_OFF_STATUS, 32'h0, 4'h0);
		chk("status_ro", 32'h7, rd);
	endtask
	task t_frame(input int c, input logic [3:0] b, input logic [7:0] f);
		int n;
		n = c * ((b > 8) ? 8 : b);
		if (n > 32767) n = 32767;
		for (int j = 0; j < c; j++) begin
			@(posedge i_mclk);
			{i_tx_bytes, i_tx_frame_end, fl} <= {b, j == c - 1, f};
		end
		@(posedge i_mclk);
		{i_tx_bytes, i_tx_frame_end} <= 5'h00;
		#1;
		nf++;
		chk("stat_valid", 1'b1, o_tx_stat_valid);
		chk("frame_len", n, o_tx_stat_vector[19:5]);
		chk("bytes_valid", b > 8 ? 8 : b, o_tx_stat_vector[24:21]);
		chk("flags", {f[7:4], f[3:1], ~f[0] & ~f[3]}, {o_tx_stat_vector[26:25],
			o_tx_stat_vector[20], o_tx_stat_vector[4:0]});
		@(posedge i_mclk);
		#1;
		chk("stat_valid_off", 1'b0, o_tx_stat_valid);
		chk("len_hold", n, o_tx_stat_vector[19:5]);
		chk("client_len", n, last[19:5]);
		chk("client_frames", nf, frames);
	endtask
	task t_counts;
		apb(1'b0, `MSV_OFF_TXFRAMES, 32'h0, 4'h0);
		chk("tx_frames", 32'h0000_000b, rd);
		apb(1'b0, `MSV_OFF_TXBAD, 32'h0, 4'h0);
		chk("tx_bad", 32'h0000_0002, rd);
		apb(1'b0, `MSV_OFF_TXSTAT, 32'h0, 4'h0);
		chk("txstat_read", 32'h000f_ffe1, rd);
	endtask
	task t_rx(input logic [3:0] c, input logic [30:0] v, input logic x);
		apb(1'b1, `MSV_OFF_RXCFG, {28'h0, c}, 4'h1);
		@(posedge i_mclk);
		{rxv, rxval} <= {v, 1'b1};
		@(posedge i_mclk);
		rxval <= 1'b0;
		#1;
		chk("rx_valid", x, orxval);
		chk("rx_vector", v, orxv);
	endtask
	task t_reset;
		@(posedge i_mclk);
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_mclk);
		chk("path_rst_mid", 1'b1, o_rx_path_rst);
		i_sys_rst <= 1'b0;
		apb(1'b0, `MSV_OFF_RXCFG, 32'h0, 4'h0);
		chk("cfg_after_rst", 32'h0, rd);
		apb(1'b0, `MSV_OFF_TXFRAMES, 32'h0, 4'h0);
		chk("frames_after_rst", 32'h0, rd);
	endtask
	initial begin
		{i_sys_rst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_pstrb}
			= {4'h8, 44'h0};
		{i_rs_local_fault, i_rs_remote_fault, i_rs_link_int} = 3'h0;
		{i_tx_bytes, i_tx_frame_end, fl} = 13'h0;
		{rxv, rxval} = 32'h0;
		repeat (12) @(posedge i_mclk);
		chk("path_rst_in_reset", 1'b1, o_rx_path_rst);
		i_sys_rst <= 1'b0;
		t_cfg;
		t_status;
		// each pass but the last sets one flag; every pass a different per-cycle byte count
		for (int k = 0; k < 9; k++)
			t_frame(2, k, 8'h01 << k);
		t_frame(1, 4'hf, 8'h00);
		// long frame to reach the length ceiling
		t_frame(4097, 4'h8, 8'h00);
		t_counts;
		t_rx(4'h2, 31'h0000_0021, 1'b1);
		t_rx(4'h2, 31'h0040_0021, 1'b0);
		t_rx(4'h6, 31'h0040_0021, 1'b1);
		t_rx(4'h4, 31'h0000_0021, 1'b0);
		t_rx(4'h7, 31'h0000_0021, 1'b0);
		apb(1'b0, `MSV_OFF_RXFRAMES, 32'h0, 4'h0);
		chk("rx_frames", 32'h0000_0002, rd);
		t_reset;
		conclude;
	end
	initial begin
		#400000;
		errors++;
		conclude;
	end
endmodule
